// ### src/risc_core_consts.svh
// Constants, opcodes and timing counts of the core execution datapath.
// Contract
// - Every instruction is one 14-bit word fetched in one cycle on its own bus.
// - Fetch of the next word overlaps execution, so non-branch instructions take one cycle.
// - Program and data memories sit on separate buses and never compete.
// - The program counter spans 1K to 8K internal words, chosen per variant.
// - Special registers, program counter included, live in data space, direct or indirect.
// - An 8-bit ALU adds, subtracts, shifts and does logic in two's complement.
// - Two-operand ops use accumulator with file or literal; single-operand use one of them.
// - The accumulator is an 8-bit operand holder with no data address.
// - Instructions update carry, nibble overflow and zero flags in the status register.
// - In subtraction carry and nibble overflow act as inverted borrows.
// - In RC mode the cycle rate output runs at a quarter of the oscillator rate.
// - A low external reset pin holds the whole device in reset.
`ifndef RISC_CORE_CONSTS_SVH
`define RISC_CORE_CONSTS_SVH

`define CLK_PERIOD_NS 100
`define INSTR_CYCLE_NS 400
`define CLKS_PER_INSTR (`INSTR_CYCLE_NS / `CLK_PERIOD_NS)
`define INSTR_W 14
`define DATA_W 8
`define PC_MAX_W 13
`define PCLATH_W 5
`define STACK_DEPTH 8
`define NOP_WORD 14'h0000
`define RETURN_WORD 14'h0008
`define ADDR_INDF 7'h00
`define ADDR_PCL 7'h02
`define ADDR_STATUS 7'h03
`define ADDR_FSR 7'h04
`define ADDR_PCLATH 7'h0a
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_RP0 5
`define STATUS_RESET 8'h18
`define STATUS_WR_MASK 8'he7

`endif

// ### src/risc_core_pkg.sv
// Types shared by the core execution datapath and its ALU.
package risc_core_pkg;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b11,
		PH_Q4 = 2'b10
	} phase_t;

	typedef enum logic [3:0] {
		ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_PASS, ALU_PASSW, ALU_CLR,
		ALU_COM, ALU_INC, ALU_DEC, ALU_RR, ALU_RL, ALU_SWAP, ALU_BCLR, ALU_BSET
	} alu_op_t;

	typedef struct packed {
		alu_op_t op;
		logic use_lit;
		logic to_file;
		logic to_w;
		logic aff_z;
		logic aff_dc;
		logic aff_c;
		logic skip_zero;
		logic skip_bit;
		logic skip_set;
		logic go;
		logic call;
		logic ret;
	} ctl_t;

	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic rc_s1;
		logic rc_s2;
		phase_t phase;
		logic [12:0] pc;
		logic [13:0] ir;
		logic [7:0] w;
		logic [7:0] status;
		logic [7:0] fsr;
		logic [4:0] pclath;
		logic [7:0][12:0] stack;
		logic [2:0] sp;
		logic [7:0] opnd;
		logic [7:0] data_addr;
		logic [7:0] data_wdata;
		logic data_we;
		logic cycle_rate;
	} state_t;

endpackage : risc_core_pkg

// ### src/alu_unit.sv
// Eight-bit ALU with carry, nibble overflow and zero results.
`timescale 1ns/1ps
`include "risc_core_consts.svh"
module alu_unit (
	input wire risc_core_pkg::alu_op_t op,
	input wire logic [7:0] acc,
	input wire logic [7:0] opnd,
	input wire logic [2:0] bit_sel,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic carry_out,
	output logic digit_out,
	output logic zero
);
	import risc_core_pkg::*;

	logic [8:0] sum;
	logic [4:0] nib;

	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		result = opnd;
		carry_out = carry_in;
		digit_out = 1'b0;
		case (op)
			ALU_ADD: begin
				sum = {1'b0, opnd} + {1'b0, acc};
				nib = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
				result = sum[7:0];
				carry_out = sum[8];
				digit_out = nib[4];
			end
			ALU_SUB: begin
				// Two's complement add of the inverted accumulator; carry high means no borrow.
				sum = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
				nib = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
				result = sum[7:0];
				carry_out = sum[8];
				digit_out = nib[4];
			end
			ALU_AND: result = opnd & acc;
			ALU_IOR: result = opnd | acc;
			ALU_XOR: result = opnd ^ acc;
			ALU_PASS: result = opnd;
			ALU_PASSW: result = acc;
			ALU_CLR: result = 8'h00;
			ALU_COM: result = ~opnd;
			ALU_INC: result = opnd + 8'h01;
			ALU_DEC: result = opnd - 8'h01;
			ALU_RR: begin
				result = {carry_in, opnd[7:1]};
				carry_out = opnd[0];
			end
			ALU_RL: begin
				result = {opnd[6:0], carry_in};
				carry_out = opnd[7];
			end
			ALU_SWAP: result = {opnd[3:0], opnd[7:4]};
			ALU_BCLR: result = opnd & ~(8'h01 << bit_sel);
			ALU_BSET: result = opnd | (8'h01 << bit_sel);
			default: result = opnd;
		endcase
	end

	assign zero = (result == 8'h00);

endmodule : alu_unit

// ### src/risc_core_datapath.sv
// Core execution datapath: fetch pipeline, accumulator, special registers and call stack.
`timescale 1ns/1ps
`include "risc_core_consts.svh"
module risc_core_datapath #(
	parameter int PC_W = 13
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic EXTERNAL_RESET_PIN_N,
	input wire logic RC_MODE,
	output logic [12:0] PROG_ADDR,
	input wire logic [13:0] PROG_DATA,
	output logic [7:0] DATA_ADDR,
	input wire logic [7:0] DATA_RDATA,
	output logic [7:0] DATA_WDATA,
	output logic DATA_WE,
	output logic CYCLE_RATE_OUTPUT
);
	import risc_core_pkg::*;

	// Only the 1K to 8K word variants exist, so other program counter widths are refused.
	if (PC_W < 10 || PC_W > `PC_MAX_W) begin : g_bad_pc_w
		$error("PC_W must lie between 10 and 13");
	end

	state_t cur;
	state_t next_cur;
	ctl_t ctl;
	logic [7:0] eff_addr;
	logic [7:0] b_in;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_dc;
	logic alu_z;
	logic core_reg;
	logic [7:0] core_rd;
	logic bit_val;

	function automatic ctl_t decode(input logic [13:0] ir);
		ctl_t c;
		c = '0;
		c.op = ALU_PASS;
		case (ir[13:12])
			2'b00: begin
				c.to_file = ir[7];
				c.to_w = ~ir[7];
				c.aff_z = 1'b1;
				case (ir[11:8])
					4'h0: begin
						c.to_w = 1'b0;
						c.aff_z = 1'b0;
						c.op = ALU_PASSW;
						c.ret = (ir == `RETURN_WORD);
					end
					4'h1: c.op = ALU_CLR;
					4'h2: begin
						c.op = ALU_SUB;
						c.aff_c = 1'b1;
						c.aff_dc = 1'b1;
					end
					4'h3: c.op = ALU_DEC;
					4'h4: c.op = ALU_IOR;
					4'h5: c.op = ALU_AND;
					4'h6: c.op = ALU_XOR;
					4'h7: begin
						c.op = ALU_ADD;
						c.aff_c = 1'b1;
						c.aff_dc = 1'b1;
					end
					4'h8: c.op = ALU_PASS;
					4'h9: c.op = ALU_COM;
					4'ha: c.op = ALU_INC;
					4'hb: begin
						c.op = ALU_DEC;
						c.aff_z = 1'b0;
						c.skip_zero = 1'b1;
					end
					4'hc: begin
						c.op = ALU_RR;
						c.aff_z = 1'b0;
						c.aff_c = 1'b1;
					end
					4'hd: begin
						c.op = ALU_RL;
						c.aff_z = 1'b0;
						c.aff_c = 1'b1;
					end
					4'he: begin
						c.op = ALU_SWAP;
						c.aff_z = 1'b0;
					end
					4'hf: begin
						c.op = ALU_INC;
						c.aff_z = 1'b0;
						c.skip_zero = 1'b1;
					end
					default: c.op = ALU_PASS;
				endcase
			end
			2'b01: begin
				c.op = ir[10] ? ALU_BSET : ALU_BCLR;
				c.to_file = ~ir[11];
				c.skip_bit = ir[11];
				c.skip_set = ir[10];
			end
			2'b10: begin
				c.go = ir[11];
				c.call = ~ir[11];
			end
			default: begin
				c.use_lit = 1'b1;
				c.to_w = 1'b1;
				case (ir[11:10])
					2'b00: c.op = ALU_PASS;
					2'b01: begin
						c.op = ALU_PASS;
						c.ret = 1'b1;
					end
					2'b10: begin
						c.aff_z = ~(ir[9] & ir[8]);
						c.to_w = ~(ir[9] & ir[8]);
						c.op = ir[9] ? ALU_XOR : (ir[8] ? ALU_AND : ALU_IOR);
					end
					default: begin
						c.op = ir[9] ? ALU_ADD : ALU_SUB;
						c.aff_z = 1'b1;
						c.aff_c = 1'b1;
						c.aff_dc = 1'b1;
					end
				endcase
			end
		endcase
		return c;
	endfunction : decode

	function automatic logic [12:0] wrap_pc(input logic [12:0] pc);
		return pc & ((13'h0001 << PC_W) - 13'h0001);
	endfunction : wrap_pc

	function automatic logic is_core_reg(input logic [6:0] a);
		return a == `ADDR_INDF || a == `ADDR_PCL || a == `ADDR_STATUS || a == `ADDR_FSR || a == `ADDR_PCLATH;
	endfunction : is_core_reg

	assign ctl = decode(cur.ir);
	// Address 0 reaches memory through the pointer register instead of directly.
	assign eff_addr = (cur.ir[6:0] == `ADDR_INDF) ? cur.fsr : {cur.status[`ST_RP0], cur.ir[6:0]};
	assign core_reg = is_core_reg(eff_addr[6:0]);
	assign b_in = ctl.use_lit ? cur.ir[7:0] : cur.opnd;
	assign bit_val = cur.opnd[cur.ir[9:7]];

	always_comb begin
		case (eff_addr[6:0])
			`ADDR_PCL: core_rd = cur.pc[7:0];
			`ADDR_STATUS: core_rd = cur.status;
			`ADDR_FSR: core_rd = cur.fsr;
			`ADDR_PCLATH: core_rd = {3'h0, cur.pclath};
			default: core_rd = 8'h00;
		endcase
	end

	alu_unit alu (
		.op(ctl.op),
		.acc(cur.w),
		.opnd(b_in),
		.bit_sel(cur.ir[9:7]),
		.carry_in(cur.status[`ST_C]),
		.result(alu_res),
		.carry_out(alu_c),
		.digit_out(alu_dc),
		.zero(alu_z)
	);

	always_comb begin
		next_cur = cur;
		next_cur.rst_s1 = EXTERNAL_RESET_PIN_N;
		next_cur.rst_s2 = cur.rst_s1;
		next_cur.rc_s1 = RC_MODE;
		next_cur.rc_s2 = cur.rc_s1;
		case (cur.phase)
			PH_Q1: begin
				next_cur.phase = PH_Q2;
				next_cur.data_addr = eff_addr;
			end
			PH_Q2: begin
				next_cur.phase = PH_Q3;
				next_cur.opnd = core_reg ? core_rd : DATA_RDATA;
			end
			PH_Q3: begin
				next_cur.phase = PH_Q4;
				next_cur.data_wdata = alu_res;
				next_cur.data_we = ctl.to_file & ~core_reg;
			end
			PH_Q4: begin
				next_cur.phase = PH_Q1;
				next_cur.data_we = 1'b0;
				// The word on the program bus was fetched while this instruction executed.
				next_cur.ir = PROG_DATA;
				next_cur.pc = wrap_pc(cur.pc + 13'h0001);
				if (ctl.to_w) begin
					next_cur.w = alu_res;
				end
				if (ctl.to_file && core_reg) begin
					case (eff_addr[6:0])
						`ADDR_PCL: begin
							next_cur.pc = wrap_pc({cur.pclath, alu_res});
							next_cur.ir = `NOP_WORD;
						end
						`ADDR_STATUS: next_cur.status = (cur.status & ~`STATUS_WR_MASK) | (alu_res & `STATUS_WR_MASK);
						`ADDR_FSR: next_cur.fsr = alu_res;
						`ADDR_PCLATH: next_cur.pclath = alu_res[4:0];
						default: next_cur.fsr = cur.fsr;
					endcase
				end
				if (ctl.aff_z) begin
					next_cur.status[`ST_Z] = alu_z;
				end
				if (ctl.aff_c) begin
					next_cur.status[`ST_C] = alu_c;
				end
				if (ctl.aff_dc) begin
					next_cur.status[`ST_DC] = alu_dc;
				end
				if ((ctl.skip_zero && alu_z) || (ctl.skip_bit && bit_val == ctl.skip_set)) begin
					next_cur.ir = `NOP_WORD;
				end
				if (ctl.call) begin
					next_cur.stack[cur.sp] = cur.pc;
					next_cur.sp = cur.sp + 3'h1;
				end
				if (ctl.go || ctl.call) begin
					next_cur.pc = wrap_pc({cur.pclath[4:3], cur.ir[10:0]});
					next_cur.ir = `NOP_WORD;
				end
				if (ctl.ret) begin
					next_cur.sp = cur.sp - 3'h1;
					next_cur.pc = cur.stack[cur.sp - 3'h1];
					next_cur.ir = `NOP_WORD;
				end
			end
			default: next_cur.phase = PH_Q1;
		endcase
		// In RC mode, high for the first half of every four-clock instruction cycle; low otherwise.
		next_cur.cycle_rate = cur.rc_s2 && (next_cur.phase == PH_Q1 || next_cur.phase == PH_Q2);
		if (!cur.rst_s2) begin
			next_cur = '0;
			next_cur.rst_s1 = EXTERNAL_RESET_PIN_N;
			next_cur.rst_s2 = cur.rst_s1;
			next_cur.rc_s1 = RC_MODE;
			next_cur.rc_s2 = cur.rc_s1;
			next_cur.status = `STATUS_RESET;
		end
		if (!CE) begin
			next_cur = cur;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cur <= '0;
			cur.status <= `STATUS_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	assign PROG_ADDR = cur.pc;
	assign DATA_ADDR = cur.data_addr;
	assign DATA_WDATA = cur.data_wdata;
	assign DATA_WE = cur.data_we;
	assign CYCLE_RATE_OUTPUT = cur.cycle_rate;

endmodule : risc_core_datapath

// ### verification/core_monitor.sv
// Checker of the core execution datapath ports.
`timescale 1ns/1ps
module core_monitor #(
	parameter int PC_W = 13
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic EXTERNAL_RESET_PIN_N,
	input wire logic RC_MODE,
	input wire logic [12:0] PROG_ADDR,
	input wire logic [13:0] PROG_DATA,
	input wire logic [7:0] DATA_ADDR,
	input wire logic [7:0] DATA_RDATA,
	input wire logic [7:0] DATA_WDATA,
	input wire logic DATA_WE,
	input wire logic CYCLE_RATE_OUTPUT
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	we_single_pulse_a:
	assert property (DATA_WE |=> !DATA_WE [*3]) else $error("write strobe not once per cycle");
	core_reg_guard_a:
	assert property (DATA_WE |-> !(DATA_ADDR[6:0] inside {7'h00, 7'h02, 7'h03, 7'h04, 7'h0a}))
		else $error("core register written outside");
	// A pin reset may cut an instruction cycle short, so it aborts the check.
	fetch_hold_a:
	assert property (disable iff (RESET || !EXTERNAL_RESET_PIN_N)
		$changed(PROG_ADDR) |=> $stable(PROG_ADDR) [*3]) else $error("fetch address not held");
	pc_span_a:
	assert property ((PROG_ADDR >> PC_W) == 13'h0000) else $error("fetch address out of range");
	rate_wave_a:
	assert property (disable iff (RESET || !CE || !RC_MODE || !EXTERNAL_RESET_PIN_N)
		$fell(CYCLE_RATE_OUTPUT) |=> !CYCLE_RATE_OUTPUT ##1 CYCLE_RATE_OUTPUT [*2] ##1 !CYCLE_RATE_OUTPUT)
		else $error("cycle rate output not a quarter");
	rate_off_a:
	assert property (!RC_MODE [*4] |-> !CYCLE_RATE_OUTPUT) else $error("cycle rate output outside RC mode");
	pin_reset_a:
	assert property (!EXTERNAL_RESET_PIN_N [*4] |-> PROG_ADDR == 13'h0000 && !DATA_WE)
		else $error("pin reset not holding");
	write_addr_hold_a:
	assert property (DATA_WE |-> $stable(DATA_ADDR) && $past(DATA_ADDR, 2) == DATA_ADDR)
		else $error("data address moved before write");
endmodule : core_monitor

bind risc_core_datapath core_monitor #(.PC_W(PC_W)) u_core_monitor (.CLK(CLK), .RESET(RESET), .CE(CE),
	.EXTERNAL_RESET_PIN_N(EXTERNAL_RESET_PIN_N), .RC_MODE(RC_MODE), .PROG_ADDR(PROG_ADDR),
	.PROG_DATA(PROG_DATA), .DATA_ADDR(DATA_ADDR), .DATA_RDATA(DATA_RDATA), .DATA_WDATA(DATA_WDATA),
	.DATA_WE(DATA_WE), .CYCLE_RATE_OUTPUT(CYCLE_RATE_OUTPUT));

// ### verification/core_memory_model.sv
// Behavioural program memory and data file facing the core datapath.
`timescale 1ns/1ps
module core_memory_model (
	input wire logic CLK,
	input wire logic [12:0] PROG_ADDR,
	output logic [13:0] PROG_DATA,
	input wire logic [7:0] DATA_ADDR,
	output logic [7:0] DATA_RDATA,
	input wire logic [7:0] DATA_WDATA,
	input wire logic DATA_WE
);
	logic [13:0] rom [0:8191];
	logic [7:0] ram [0:255];
	initial begin
		for (int i = 0; i < 8192; i++) begin
			rom[i] = 14'h0000;
		end
		for (int i = 0; i < 256; i++) begin
			ram[i] = 8'(i) ^ 8'ha5;
		end
	end
	// Program and data answer on their own buses, one whole word per address.
	assign PROG_DATA = rom[PROG_ADDR];
	assign DATA_RDATA = ram[DATA_ADDR];
	always @(posedge CLK) begin
		if (DATA_WE) begin
			ram[DATA_ADDR] <= DATA_WDATA;
		end
	end
endmodule : core_memory_model

// ### verification/risc_core_datapath_tb.sv
// Self-checking testbench for the core execution datapath.
`timescale 1ns/1ps
module risc_core_datapath_tb;
	localparam int PC_W = 11;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic CE = 1'b1;
	logic EXTERNAL_RESET_PIN_N = 1'b0;
	logic RC_MODE = 1'b1;
	logic [12:0] PROG_ADDR;
	logic [13:0] PROG_DATA;
	logic [7:0] DATA_ADDR;
	logic [7:0] DATA_RDATA;
	logic [7:0] DATA_WDATA;
	logic DATA_WE;
	logic CYCLE_RATE_OUTPUT;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [15:0] expect_q[$];
	logic [13:0] lit_op [0:4] = '{14'h3e00, 14'h3c00, 14'h3900, 14'h3800, 14'h3a00};
	logic [12:0] pc;
	logic [7:0] a, b, res;
	logic c, dc, z;
	int op;
	risc_core_datapath #(.PC_W(PC_W)) u_risc_core_datapath (.CLK(CLK), .RESET(RESET), .CE(CE),
		.EXTERNAL_RESET_PIN_N(EXTERNAL_RESET_PIN_N), .RC_MODE(RC_MODE), .PROG_ADDR(PROG_ADDR),
		.PROG_DATA(PROG_DATA), .DATA_ADDR(DATA_ADDR), .DATA_RDATA(DATA_RDATA), .DATA_WDATA(DATA_WDATA),
		.DATA_WE(DATA_WE), .CYCLE_RATE_OUTPUT(CYCLE_RATE_OUTPUT));
	core_memory_model u_core_memory_model (.CLK(CLK), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA),
		.DATA_ADDR(DATA_ADDR), .DATA_RDATA(DATA_RDATA), .DATA_WDATA(DATA_WDATA), .DATA_WE(DATA_WE));
	initial begin
		forever #50 CLK = ~CLK;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize
	task automatic put(input logic [13:0] word);
		u_core_memory_model.rom[pc] = word;
		pc++;
	endtask : put
	// Writes are taken at the falling edge, where the strobe has settled.
	always @(negedge CLK) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			summarize();
		end else if (DATA_WE === 1'b1 && expect_q.size() == 0) begin
			check("stray write", {DATA_ADDR, DATA_WDATA}, 16'hffff);
		end else if (DATA_WE === 1'b1) begin
			check("file write", {DATA_ADDR, DATA_WDATA}, expect_q.pop_front());
		end
	end
	initial begin
		#1;
		void'($urandom(32'hd2a3));
		pc = 13'h0000;
		c = 1'b0;
		dc = 1'b0;
		// Each block runs a literal operation, stores result and flags, then jumps over a stray store.
		for (int i = 0; i < 12; i++) begin
			a = 8'($urandom());
			b = 8'($urandom());
			op = (i < 5) ? i : $urandom_range(4);
			put(14'h3000 | a);
			put(lit_op[op] | b);
			case (op)
				0: begin
					{c, res} = a + b;
					dc = a[3:0] + b[3:0] > 15;
				end
				1: begin
					res = b - a;
					c = b >= a;
					dc = b[3:0] >= a[3:0];
				end
				2: res = a & b;
				3: res = a | b;
				default: res = a ^ b;
			endcase
			z = res == 8'h00;
			put(14'h00a0);
			put(14'h0803);
			put(14'h00a1);
			put(14'h2800 | (pc + 13'h0002));
			put(14'h00a2);
			expect_q.push_back({8'h20, res});
			expect_q.push_back({8'h21, 8'h18 | {z, dc, c}});
		end
		// A pointer store, a call and return, a rotate and a skip over a stray store close the program.
		a = 8'($urandom());
		res = a + 8'h01;
		put(14'h3030);
		put(14'h0084);
		put(14'h3000 | a);
		put(14'h0080);
		put(14'h2000 | (pc + 13'h0006));
		put(14'h00a2);
		put(14'h0ca2);
		put(14'h1d83);
		put(14'h00a2);
		put(14'h2800 | pc);
		put(14'h0a00);
		put(14'h0008);
		expect_q.push_back({8'h30, a});
		expect_q.push_back({8'h22, res});
		expect_q.push_back({8'h22, c, res[7:1]});
		repeat (4) @(negedge CLK);
		RESET = 1'b0;
		repeat (6) @(negedge CLK);
		EXTERNAL_RESET_PIN_N = 1'b1;
		for (int i = 0; i < 2000 && expect_q.size() > 0; i++) begin
			@(negedge CLK);
		end
		repeat (40) @(negedge CLK);
		check("pending writes", 16'(expect_q.size()), 16'h0000);
		pc = PROG_ADDR;
		CE = 1'b0;
		repeat ($urandom_range(9, 5)) @(negedge CLK);
		check("frozen fetch", {3'h0, PROG_ADDR}, {3'h0, pc});
		CE = 1'b1;
		RC_MODE = 1'b0;
		EXTERNAL_RESET_PIN_N = 1'b0;
		repeat (10) @(negedge CLK);
		check("cycle rate off", {15'h0000, CYCLE_RATE_OUTPUT}, 16'h0000);
		check("held fetch", {3'h0, PROG_ADDR}, 16'h0000);
		summarize();
	end
endmodule : risc_core_datapath_tb
